/* bct_pkg.sv */
package bct_pkg;

   // Register byte addresses on the APB slave.
   localparam logic [7:0] ADDR_DIV_LOW   = 8'h00;
   localparam logic [7:0] ADDR_DIV_HIGH  = 8'h04;
   localparam logic [7:0] ADDR_AUX_CTRL  = 8'h08;
   localparam logic [7:0] ADDR_CMD_A     = 8'h0C;
   localparam logic [7:0] ADDR_CMD_B     = 8'h10;
   localparam logic [7:0] ADDR_INT_STAT  = 8'h14;
   localparam logic [7:0] ADDR_INT_MASK  = 8'h18;
   localparam logic [7:0] ADDR_START_CMD = 8'h1C;
   localparam logic [7:0] ADDR_STOP_CMD  = 8'h20;
   localparam logic [7:0] ADDR_CLK_SEL   = 8'h24;
   localparam logic [7:0] ADDR_COUNT     = 8'h28;

   // Field positions.
   localparam int CNT_READY_BIT = 3;
   localparam int AUX_MODE_LSB  = 4;
   localparam int AUX_MODE_MSB  = 6;
   localparam int AUX_SQUARE_BIT = 6;
   localparam int AUX_EXTCLK_BIT = 4;

   // Command codes, upper nibble of a channel command write.
   localparam logic [3:0] CMD_TIMEOUT_ON  = 4'hA;
   localparam logic [3:0] CMD_TIMEOUT_OFF = 4'hC;

   // Reset values, and the 16-bit one and zero used by the counter.
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [15:0] RST_COUNT = 16'hFFFF;
   localparam logic [15:0] ONE_16    = 16'h0001;
   localparam logic [15:0] ZERO_16   = 16'h0000;

   // Clock divider for the internal timer clock when no external source.
   localparam int PRESCALE_DEFAULT = 4;

   // Clock select code that routes the counter to a channel (16x mode).
   localparam logic [3:0] CSR_USE_TIMER = 4'hD;

   typedef enum logic [1:0] {
      BCT_IDLE,
      BCT_RUN,
      BCT_HOLD,
      BCT_RELOAD
   } bct_state_t;

endpackage : bct_pkg

/* bct_tick_gen.sv */
`timescale 1ns/1ps
// Produces the one-cycle timer clock enable from the prescaler or an
// external source already synchronous to pclk.
module bct_tick_gen
   import bct_pkg::*;
#(
   parameter int PRESCALE = PRESCALE_DEFAULT
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic use_ext,
   input  wire logic ext_clk,
   output logic      tick
);
   localparam int W = $clog2(PRESCALE + 1);
   logic [W-1:0] div_reg;
   logic         ext_reg;
   wire          div_wrap = (div_reg == W'(PRESCALE - 1));
   wire          ext_rise = ext_clk & ~ext_reg;

   // The divider free-runs; an external edge replaces it when chosen.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= '0;
         ext_reg <= 1'b0;
      end else begin
         div_reg <= div_wrap ? '0 : div_reg + W'(1);
         ext_reg <= ext_clk;
      end
   end

   assign tick = use_ext ? ext_rise : div_wrap;
endmodule : bct_tick_gen

/* bct_counter_timer.sv */
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module bct_counter_timer
   import bct_pkg::*;
#(
   parameter int PRESCALE = PRESCALE_DEFAULT
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext_timer_clk,
   input  wire logic        rx_load_a,
   input  wire logic        rx_load_b,
   output logic             timer_out,
   output logic             irq,
   output logic             sample16x_a,
   output logic             sample16x_b
);

   logic [7:0]  divisor_low_byte;
   logic [7:0]  divisor_high_byte;
   logic [2:0]  aux_control_reg;
   logic [7:0]  clock_select_reg;
   logic [7:0]  interrupt_status_reg;
   logic [7:0]  interrupt_mask_reg;
   logic [15:0] count_reg;
   logic [15:0] count_next;
   logic        out_reg;
   logic        out_next;
   logic        to_a_reg;
   logic        to_b_reg;
   logic        ready_next;
   bct_state_t  state_reg;
   bct_state_t  state_next;
   logic [31:0] prdata_reg;
   logic        irq_reg;
   logic        s16a_reg;
   logic        s16b_reg;
   logic        perr_reg;
   logic        tick;

   // Bus decode: access phase is the single cycle in which effects happen.
   wire         access   = psel & penable;
   wire         wr       = access & pwrite;
   wire         rd       = access & ~pwrite;
   wire [15:0]  divisor  = {divisor_high_byte, divisor_low_byte};
   wire         square   = aux_control_reg[AUX_SQUARE_BIT - AUX_MODE_LSB];
   wire         use_ext  = aux_control_reg[AUX_EXTCLK_BIT - AUX_MODE_LSB];
   wire         timeout  = to_a_reg | to_b_reg;
   wire         cmd_a_wr = wr & (paddr == ADDR_CMD_A);
   wire         cmd_b_wr = wr & (paddr == ADDR_CMD_B);
   wire [3:0]   cmd_code = pwdata[7:4];
   wire         to_on    = (cmd_a_wr | cmd_b_wr) & (cmd_code == CMD_TIMEOUT_ON);
   // Start/stop are read-triggered; write data plays no part.
   wire         start_rd = rd & (paddr == ADDR_START_CMD) & ~timeout;
   wire         stop_rd  = rd & (paddr == ADDR_STOP_CMD) & ~timeout;
   // A load on either channel with its timeout enabled restarts the shared counter.
   wire         rx_load  = (rx_load_a & to_a_reg) | (rx_load_b & to_b_reg);
   wire         at_one   = (count_reg == ONE_16);
   wire         at_zero  = (count_reg == ZERO_16);
   wire         fall     = out_reg & ~out_next;
   wire         mapped   = (paddr <= ADDR_COUNT) && (paddr[1:0] == 2'b00);

   bct_tick_gen #(
      .PRESCALE (PRESCALE)
   ) u_tick (
      .pclk     (pclk),
      .presetn  (presetn),
      .use_ext  (use_ext),
      .ext_clk  (ext_timer_clk),
      .tick     (tick)
   );

   // Counter state machine. The reload pause costs one tick, which is why a
   // timeout always lasts a tick longer than the divisor alone.
   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      out_next   = out_reg;
      unique case (state_reg)
         BCT_IDLE: begin
            // Stopped with the count frozen; only a start or a timeout-enable command moves it on.
         end
         BCT_RUN: begin
            if (tick) begin
               if (square) begin
                  // Half period is the divisor; reload and toggle at one.
                  if (at_one || at_zero) begin
                     count_next = divisor;
                     out_next   = ~out_reg;
                  end else begin
                     count_next = count_reg - ONE_16;
                  end
               end else begin
                  // Wraps through zero to the top and keeps going quietly.
                  count_next = count_reg - ONE_16;
                  if (at_one) begin
                     out_next = 1'b0;
                  end
               end
            end
         end
         BCT_HOLD: begin
            // Parked after timeout-enable until the first character.
         end
         BCT_RELOAD: begin
            if (tick) begin
               count_next = divisor;
               out_next   = 1'b1;
               state_next = BCT_RUN;
            end
         end
      endcase
      // A square wave keeps running through a stop; only counter mode halts.
      if (stop_rd && !square) begin
         state_next = BCT_IDLE;
      end
      // Start reloads from any state while no timeout is enabled, so a running count never carries on.
      if (start_rd) begin
         count_next = divisor;
         out_next   = 1'b1;
         state_next = BCT_RUN;
      end
      if (to_on) begin
         state_next = BCT_HOLD;
      end else if (rx_load) begin
         state_next = BCT_RELOAD;
      end
   end

   // Counter-ready: hardware set wins over the stop clear.
   always_comb begin
      ready_next = interrupt_status_reg[CNT_READY_BIT];
      if (stop_rd || to_on || rx_load) begin
         ready_next = 1'b0;
      end
      if (fall && !rx_load && !to_on) begin
         ready_next = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= BCT_IDLE;
         count_reg <= RST_COUNT;
         out_reg   <= 1'b1;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         out_reg   <= out_next;
      end
   end

   // Software registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         divisor_low_byte   <= RST_BYTE;
         divisor_high_byte  <= RST_BYTE;
         aux_control_reg    <= '0;
         clock_select_reg   <= RST_BYTE;
         interrupt_mask_reg <= RST_BYTE;
         to_a_reg           <= 1'b0;
         to_b_reg           <= 1'b0;
      end else begin
         if (wr && paddr == ADDR_DIV_LOW) divisor_low_byte <= pwdata[7:0];
         if (wr && paddr == ADDR_DIV_HIGH) divisor_high_byte <= pwdata[7:0];
         if (wr && paddr == ADDR_AUX_CTRL) begin
            aux_control_reg <= pwdata[AUX_MODE_MSB:AUX_MODE_LSB];
         end
         if (wr && paddr == ADDR_CLK_SEL) clock_select_reg <= pwdata[7:0];
         if (wr && paddr == ADDR_INT_MASK) interrupt_mask_reg <= pwdata[7:0];
         if (cmd_a_wr && cmd_code == CMD_TIMEOUT_ON) to_a_reg <= 1'b1;
         if (cmd_a_wr && cmd_code == CMD_TIMEOUT_OFF) to_a_reg <= 1'b0;
         if (cmd_b_wr && cmd_code == CMD_TIMEOUT_ON) to_b_reg <= 1'b1;
         if (cmd_b_wr && cmd_code == CMD_TIMEOUT_OFF) to_b_reg <= 1'b0;
      end
   end

   // Status holds only the counter-ready source, so a withdrawn timeout
   // reads back as all zeros.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_status_reg <= RST_BYTE;
      end else begin
         interrupt_status_reg[CNT_READY_BIT] <= ready_next;
      end
   end

   // Read mux; the count is live and may shift between reads.
   wire [31:0] rd_mux =
      (paddr == ADDR_DIV_LOW)  ? {24'h0, divisor_low_byte} :
      (paddr == ADDR_DIV_HIGH) ? {24'h0, divisor_high_byte} :
      (paddr == ADDR_AUX_CTRL) ? {25'h0, aux_control_reg, 4'h0} :
      (paddr == ADDR_CLK_SEL)  ? {24'h0, clock_select_reg} :
      (paddr == ADDR_INT_STAT) ? {24'h0, interrupt_status_reg} :
      (paddr == ADDR_INT_MASK) ? {24'h0, interrupt_mask_reg} :
      (paddr == ADDR_CMD_A)    ? {31'h0, to_a_reg} :
      (paddr == ADDR_CMD_B)    ? {31'h0, to_b_reg} :
      (paddr == ADDR_COUNT)    ? {16'h0, count_reg} : 32'h0;

   // Outputs registered except pready, which is tied high; the slave answers in the access cycle via setup.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0;
         irq_reg    <= 1'b0;
         s16a_reg   <= 1'b0;
         s16b_reg   <= 1'b0;
         perr_reg   <= 1'b0;
      end else begin
         // The error answer is decided in setup so it stands in the access cycle.
         perr_reg <= psel & ~penable & ~mapped;
         if (psel && !penable && !pwrite) prdata_reg <= rd_mux;
         irq_reg  <= ready_next & interrupt_mask_reg[CNT_READY_BIT];
         s16a_reg <= (clock_select_reg[3:0] == CSR_USE_TIMER);
         s16b_reg <= (clock_select_reg[7:4] == CSR_USE_TIMER);
      end
   end

   assign prdata      = prdata_reg;
   assign pready      = 1'b1;
   assign pslverr     = perr_reg;
   assign timer_out   = out_reg;
   assign irq         = irq_reg;
   assign sample16x_a = s16a_reg;
   assign sample16x_b = s16b_reg;

   // Assertions.
   a_stop_clears: assert property (@(posedge pclk) disable iff (!presetn)
      stop_rd && !fall |=> !interrupt_status_reg[CNT_READY_BIT])
      else $error("stop did not clear ready");
   a_fall_sets: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(timer_out) && !$past(rx_load) && !$past(to_on)
      |-> interrupt_status_reg[CNT_READY_BIT])
      else $error("output fall did not set ready");
   a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
      irq == (interrupt_status_reg[CNT_READY_BIT] & interrupt_mask_reg[CNT_READY_BIT])
      || $changed(interrupt_mask_reg))
      else $error("irq mismatch");
   a_load_withdraws: assert property (@(posedge pclk) disable iff (!presetn)
      rx_load |=> !irq && !interrupt_status_reg[CNT_READY_BIT])
      else $error("load did not withdraw");
   a_enable_holds: assert property (@(posedge pclk) disable iff (!presetn)
      to_on |=> state_reg == BCT_HOLD && !interrupt_status_reg[CNT_READY_BIT])
      else $error("timeout enable did not hold");
   a_start_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      timeout && state_reg == BCT_HOLD && !rx_load && !to_on |=> state_reg == BCT_HOLD)
      else $error("start acted in timeout mode");
   a_start_loads: assert property (@(posedge pclk) disable iff (!presetn)
      start_rd && !rx_load && !to_on |=> count_reg == divisor && timer_out)
      else $error("start did not load");
   a_reload_step: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == BCT_RELOAD && tick && !rx_load && !to_on
      |=> state_reg == BCT_RUN && count_reg == divisor)
      else $error("reload not taken");
   a_status_zero: assert property (@(posedge pclk) disable iff (!presetn)
      rx_load |=> interrupt_status_reg == RST_BYTE)
      else $error("status not zero");
   c_square: cover property (@(posedge pclk) disable iff (!presetn)
      square && $fell(timer_out));
   c_timeout: cover property (@(posedge pclk) disable iff (!presetn)
      timeout && $rose(irq));
   c_withdraw: cover property (@(posedge pclk) disable iff (!presetn)
      irq ##1 rx_load ##1 !irq);
   c_one_shot: cover property (@(posedge pclk) disable iff (!presetn)
      !square && !timeout && $fell(timer_out));
   c_restart_run: cover property (@(posedge pclk) disable iff (!presetn)
      state_reg == BCT_RUN && start_rd);

   // Counter mode wraps to the top after zero and stays quiet there.
   a_wrap_top: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == BCT_RUN && !square && tick && at_zero && !start_rd
      |=> count_reg == RST_COUNT)
      else $error("count did not wrap to the top");
   a_wrap_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == BCT_RUN && !square && !at_one && !start_rd
      |=> $stable(timer_out))
      else $error("output moved away from the end of count");
   // The end of a one-shot count drops the output and raises ready.
   a_one_shot_fall: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == BCT_RUN && !square && tick && at_one && timer_out
      && !start_rd && !rx_load && !to_on
      |=> !timer_out && interrupt_status_reg[CNT_READY_BIT])
      else $error("one-shot end not seen");
   // Each half period ends with a toggle of the square wave.
   a_square_toggle: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == BCT_RUN && square && tick && (at_one || at_zero) && !start_rd
      |=> $changed(timer_out))
      else $error("square wave did not toggle");
   // A channel clocked from the timer is told to sample at 16x.
   a_sixteen_x: assert property (@(posedge pclk) disable iff (!presetn)
      clock_select_reg[3:0] == CSR_USE_TIMER |=> sample16x_a)
      else $error("16x sampling not selected");
endmodule : bct_counter_timer

/* bct_rx_source.sv */
`timescale 1ns/1ps
// Receive side stand-in: each bench request becomes one load pulse, as a
// receiver does when it moves a finished character into its queue.
module bct_rx_source
   import bct_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic send_a,
   input  wire logic send_b,
   output logic      rx_load_a,
   output logic      rx_load_b
);
   logic send_a_q;
   logic send_b_q;

   // Edge detection keeps a load to one cycle even if a request is held long.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         send_a_q  <= 1'b0;
         send_b_q  <= 1'b0;
         rx_load_a <= 1'b0;
         rx_load_b <= 1'b0;
      end else begin
         send_a_q  <= send_a;
         send_b_q  <= send_b;
         rx_load_a <= send_a & ~send_a_q;
         rx_load_b <= send_b & ~send_b_q;
      end
   end
endmodule : bct_rx_source

/* block_counter_timer_rx_timeout_bench.sv */
`timescale 1ns/1ps
module block_counter_timer_rx_timeout_bench;
   import bct_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        ext_timer_clk = 1'b0;
   logic        send_a = 1'b0;
   logic        send_b = 1'b0;
   logic        rx_load_a;
   logic        rx_load_b;
   logic        timer_out;
   logic        irq;
   logic        s16_a;
   logic        s16_b;
   logic        err_seen;
   logic [31:0] c1;
   logic [31:0] c2;
   int          n;
   int          n1;
   int          errors = 0;
   int          total_checks = 0;

   // A prescale of one makes every pclk a timer tick, so counts read in cycles.
   bct_counter_timer #(.PRESCALE(1)) dut_u (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_timer_clk(ext_timer_clk), .rx_load_a(rx_load_a), .rx_load_b(rx_load_b),
      .timer_out(timer_out), .irq(irq), .sample16x_a(s16_a), .sample16x_b(s16_b));
   bct_rx_source src_u (.pclk(pclk), .presetn(presetn), .send_a(send_a),
      .send_b(send_b), .rx_load_a(rx_load_a), .rx_load_b(rx_load_b));

   // Clock at 25 MHz.
   always #20 pclk = ~pclk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // One APB transfer; the request is held until pready is seen high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err_seen = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      apb(1'b1, a, d, x);
   endtask : wr

   // Reads drive junk on pwdata on purpose, since it must be ignored.
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      apb(1'b0, a, 32'h5A5A_5A5A, d);
   endtask : rd

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] x;
      rd(a, x);
      check(x, exp);
   endtask : rd_chk

   task automatic in_range(input int v, input int lo, input int hi);
      check({31'h0, (v >= lo && v <= hi)}, 32'h1);
   endtask : in_range

   // Counts edges until the output or irq reaches a level, bounded.
   task automatic wait_for(input logic use_irq, input logic v, output int k);
      k = 0;
      while (((use_irq ? irq : timer_out) !== v) && k < 3000) begin
         @(posedge pclk);
         k++;
      end
   endtask : wait_for

   task automatic rx(input logic ch);
      @(posedge pclk);
      if (ch) send_b <= 1'b1;
      else send_a <= 1'b1;
      @(posedge pclk);
      send_a <= 1'b0;
      send_b <= 1'b0;
   endtask : rx

   task automatic test_done;
      if (errors == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done

   // Watchdog, far beyond the several hundred cycles the tests need.
   initial begin
      repeat (40000) @(posedge pclk);
      errors++;
      test_done();
   end

   // Main sequence.
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      check({31'h0, timer_out}, 32'h1);
      rd_chk(ADDR_INT_STAT, 32'h0);
      rd_chk(8'h3C, 32'h0);
      check({31'h0, err_seen}, 32'h1);
      check({31'h0, pready}, 32'h1);
      wr(ADDR_CLK_SEL, 32'hDD);
      repeat (2) @(posedge pclk);
      check({30'h0, s16_b, s16_a}, 32'h3);
      wr(ADDR_CLK_SEL, 32'h00);
      repeat (2) @(posedge pclk);
      check({30'h0, s16_b, s16_a}, 32'h0);
      // One-shot count of 0x0105 with the high byte in use.
      wr(ADDR_DIV_LOW, 32'h05);
      wr(ADDR_DIV_HIGH, 32'h01);
      wr(ADDR_AUX_CTRL, 32'h00);
      wr(ADDR_INT_MASK, 32'h08);
      rd(ADDR_START_CMD, c1);
      wait_for(1'b0, 1'b0, n);
      in_range(n, 16'h0105 - 3, 16'h0105 + 3);
      rd(ADDR_COUNT, c1);
      rd(ADDR_COUNT, c2);
      check({31'h0, c1[15:0] >= 16'hFF00}, 32'h1);
      check({31'h0, c2[15:0] < c1[15:0]}, 32'h1);
      repeat (50) @(posedge pclk);
      check({31'h0, timer_out}, 32'h0);
      check({31'h0, irq}, 32'h1);
      rd_chk(ADDR_INT_STAT, 32'h08);
      rd(ADDR_STOP_CMD, c1);
      rd_chk(ADDR_INT_STAT, 32'h0);
      check({31'h0, irq}, 32'h0);
      // A second start must reload rather than carry on from the wrap.
      wr(ADDR_DIV_HIGH, 32'h00);
      wr(ADDR_DIV_LOW, 32'h20);
      rd(ADDR_START_CMD, c1);
      wait_for(1'b0, 1'b1, n);
      check(n, 32'd1);
      wait_for(1'b0, 1'b0, n);
      in_range(n, 16'h0020 - 3, 16'h0020 + 3);
      // Square wave with a divisor of 8; a stop after the first fall leaves it running.
      wr(ADDR_DIV_LOW, 32'h08);
      wr(ADDR_AUX_CTRL, 32'h40);
      rd(ADDR_START_CMD, c1);
      wait_for(1'b0, 1'b1, n);
      wait_for(1'b0, 1'b0, n);
      rd(ADDR_STOP_CMD, c1);
      rd_chk(ADDR_INT_STAT, 32'h0);
      wait_for(1'b0, 1'b1, n);
      wait_for(1'b0, 1'b0, n1);
      check(n1, 32'd8);
      wait_for(1'b0, 1'b1, n);
      wait_for(1'b0, 1'b0, n1);
      check(n + n1, 32'd16);
      rd_chk(ADDR_INT_STAT, 32'h08);
      // Receive timeout on channel a, divisor 0x20.
      wr(ADDR_AUX_CTRL, 32'h00);
      wr(ADDR_DIV_LOW, 32'h20);
      wr(ADDR_CMD_A, 32'hA0);
      rd_chk(ADDR_INT_STAT, 32'h0);
      rd_chk(ADDR_CMD_A, 32'h1);
      rd(ADDR_START_CMD, c1);
      repeat (100) @(posedge pclk);
      rd_chk(ADDR_INT_STAT, 32'h0);
      rx(1'b0);
      repeat (20) @(posedge pclk);
      rx(1'b0);
      wait_for(1'b1, 1'b1, n);
      in_range(n, 32'h20, 32'h20 + 5);
      rd(ADDR_STOP_CMD, c1);
      rd_chk(ADDR_INT_STAT, 32'h08);
      rx(1'b0);
      repeat (2) @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      rd_chk(ADDR_INT_STAT, 32'h0);
      // Both channels on: a load on either keeps the timeout away.
      wr(ADDR_CMD_B, 32'hA0);
      rx(1'b0);
      repeat (20) @(posedge pclk);
      rx(1'b1);
      repeat (20) @(posedge pclk);
      rx(1'b1);
      wait_for(1'b1, 1'b1, n);
      in_range(n, 32'h20, 32'h20 + 5);
      wr(ADDR_CMD_A, 32'hC0);
      wr(ADDR_CMD_B, 32'hC0);
      rd_chk(ADDR_CMD_A, 32'h0);
      rd(ADDR_STOP_CMD, c1);
      rd_chk(ADDR_INT_STAT, 32'h0);
      // External timer clock: the fourth rising edge ends a count of four.
      wr(ADDR_DIV_LOW, 32'h04);
      wr(ADDR_AUX_CTRL, 32'h10);
      rd(ADDR_START_CMD, c1);
      for (int i = 0; i < 4; i++) begin
         repeat (3) @(posedge pclk);
         check({31'h0, timer_out}, 32'h1);
         ext_timer_clk <= 1'b1;
         @(posedge pclk);
         ext_timer_clk <= 1'b0;
      end
      repeat (2) @(posedge pclk);
      check({31'h0, timer_out}, 32'h0);
      test_done();
   end
endmodule : block_counter_timer_rx_timeout_bench
